// ---- src/lsd_top.sv ----
`timescale 1ns/1ps
module lsd_top
#(
	parameter int ENTRY_EDGES = lsd_pkg::ENTRY_EDGES
)
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic serial_clk_in,
	input wire logic serial_bit_in,
	input wire logic latch_strobe_in,
	input wire logic drive_gate_n_in,
	input wire logic [7:0] sink_channels_in,
	input wire logic [7:0] short_sense_in,
	input wire logic [7:0] hot_sense_in,
	output logic [7:0] sink_channels_out,
	output logic [7:0] sink_channels_oe_out,
	output logic serial_bit_out,
	output logic low_current_out,
	output logic load_ready_out
);

	// link domain state
	logic ls_meta;
	logic ls_sync;
	lsd_pkg::lsd_diag_t dg_meta;
	lsd_pkg::lsd_diag_t dg_sync;
	logic [7:0] shift_reg;
	logic spill;
	lsd_pkg::lsd_mode_t mode;
	logic [2:0] entry_cnt;
	logic lowcur;
	logic [7:0] next_shift_reg;
	logic next_spill;
	lsd_pkg::lsd_mode_t next_mode;
	logic [2:0] next_entry_cnt;
	logic next_lowcur;
	logic next_serial_bit;

	// system domain state
	logic [7:0] sr_meta;
	logic [7:0] sr_sync;
	logic dm_meta;
	logic dm_sync;
	logic dm_prev;
	logic lc_meta;
	logic lc_sync;
	logic st_meta;
	logic st_sync;
	logic st_prev;
	logic gt_meta;
	logic gt_sync;
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic [7:0] sh_meta;
	logic [7:0] sh_sync;
	logic [7:0] hs_meta;
	logic [7:0] hs_sync;
	lsd_pkg::lsd_word_t fifo_mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] fifo_cnt;
	logic [7:0] pattern;
	lsd_pkg::lsd_diag_t diag;
	lsd_pkg::lsd_word_t next_fifo_mem [2];
	logic next_wr_ptr;
	logic next_rd_ptr;
	logic [1:0] next_fifo_cnt;
	logic [7:0] next_pattern;
	lsd_pkg::lsd_diag_t next_diag;
	logic [7:0] next_oe;
	logic next_low_current;
	logic next_load_ready;
	logic load_edge;
	logic push;
	logic pop;

	function automatic logic any_fault(input logic [7:0] hot, input logic [7:0] open_led,
		input logic [7:0] short_led);
		any_fault = |(hot | open_led | short_led);
	endfunction

	// link domain: serial shifting and error mode stepping
	always_comb
	begin
		next_shift_reg = shift_reg;
		next_spill = spill;
		next_mode = mode;
		next_entry_cnt = entry_cnt;
		next_lowcur = lowcur;
		unique case (mode)
			lsd_pkg::LSD_NORMAL:
			begin
				next_shift_reg = {shift_reg[6:0], serial_bit_in};
				next_spill = shift_reg[7];
				if (ls_sync)
				begin
					if (entry_cnt == 3'(ENTRY_EDGES - 1))
					begin
						next_mode = lsd_pkg::LSD_GLOBAL;
						next_entry_cnt = lsd_pkg::ENTRY_CNT_RST;
						// low-current variant chosen by data pin
						next_lowcur = serial_bit_in;
					end
					else
					begin
						next_entry_cnt = entry_cnt + 3'h1;
					end
				end
				else
				begin
					next_entry_cnt = lsd_pkg::ENTRY_CNT_RST;
				end
			end
			// each edge steps the error mode
			lsd_pkg::LSD_GLOBAL:
			begin
				next_mode = lsd_pkg::LSD_OPEN;
			end
			lsd_pkg::LSD_OPEN:
			begin
				next_mode = lsd_pkg::LSD_SHORT;
			end
			lsd_pkg::LSD_SHORT:
			begin
				next_mode = lsd_pkg::LSD_TEMP;
			end
			lsd_pkg::LSD_TEMP:
			begin
				next_mode = lsd_pkg::LSD_NORMAL;
				next_lowcur = 1'h0;
			end
			default:
			begin
				next_mode = lsd_pkg::LSD_NORMAL;
			end
		endcase
	end

	always_ff @(posedge serial_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			ls_meta <= 1'h0;
			ls_sync <= 1'h0;
			dg_meta <= lsd_pkg::DIAG_RST;
			dg_sync <= lsd_pkg::DIAG_RST;
			shift_reg <= lsd_pkg::SHIFT_RST;
			spill <= 1'h0;
			mode <= lsd_pkg::LSD_NORMAL;
			entry_cnt <= lsd_pkg::ENTRY_CNT_RST;
			lowcur <= 1'h0;
		end
		else
		begin
			ls_meta <= latch_strobe_in;
			ls_sync <= ls_meta;
			dg_meta <= diag;
			dg_sync <= dg_meta;
			shift_reg <= next_shift_reg;
			spill <= next_spill;
			mode <= next_mode;
			entry_cnt <= next_entry_cnt;
			lowcur <= next_lowcur;
		end
	end

	// serial output; detail modes report their category active low
	always_comb
	begin
		next_serial_bit = spill;
		unique case (mode)
			lsd_pkg::LSD_NORMAL:
			begin
				next_serial_bit = spill;
			end
			lsd_pkg::LSD_GLOBAL:
			begin
				next_serial_bit = ~dg_sync.global_fault;
			end
			lsd_pkg::LSD_OPEN:
			begin
				next_serial_bit = ~(|dg_sync.open_led);
			end
			lsd_pkg::LSD_SHORT:
			begin
				next_serial_bit = ~(|dg_sync.short_led);
			end
			lsd_pkg::LSD_TEMP:
			begin
				next_serial_bit = ~(|dg_sync.hot);
			end
			default:
			begin
				next_serial_bit = lsd_pkg::SERIAL_OUT_RST;
			end
		endcase
	end

	always_ff @(negedge serial_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			serial_bit_out <= lsd_pkg::SERIAL_OUT_RST;
		end
		else
		begin
			serial_bit_out <= next_serial_bit;
		end
	end

	// system domain: load capture, buffer, data register, diagnostics
	assign load_edge = st_sync & ~st_prev;
	assign push = load_edge & (fifo_cnt != lsd_pkg::FIFO_DEPTH);
	// a pending word waits while diagnostics hold the channels
	assign pop = (fifo_cnt != lsd_pkg::FIFO_CNT_RST) & ~dm_sync;

	always_comb
	begin
		next_fifo_mem = fifo_mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_fifo_cnt = fifo_cnt;
		next_pattern = pattern;
		next_diag = diag;
		if (push)
		begin
			next_fifo_mem[wr_ptr] = '{sr_sync,
				any_fault(hs_sync, pin_sync & pattern, sh_sync & pattern)};
			next_wr_ptr = ~wr_ptr;
		end
		if (pop)
		begin
			next_pattern = fifo_mem[rd_ptr].pattern;
			next_diag.global_fault = fifo_mem[rd_ptr].fault;
			next_rd_ptr = ~rd_ptr;
		end
		next_fifo_cnt = fifo_cnt + 2'(push) - 2'(pop);
		if (dm_sync & dm_prev)
		begin
			next_diag.hot = diag.hot | hs_sync;
			next_diag.open_led = diag.open_led | (pin_sync & pattern);
			next_diag.short_led = diag.short_led | (sh_sync & pattern);
		end
		else
		begin
			// live sense outside a test: the link clock may stand still, so its
			// two-edge sync must already hold fresh results when a detail mode starts
			next_diag.hot = hs_sync;
			next_diag.open_led = pin_sync & pattern;
			next_diag.short_led = sh_sync & pattern;
		end
		next_oe = gt_sync ? 8'h00 : next_pattern;
		next_low_current = lc_sync & dm_sync;
		next_load_ready = next_fifo_cnt != lsd_pkg::FIFO_DEPTH;
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			sr_meta <= lsd_pkg::SHIFT_RST;
			sr_sync <= lsd_pkg::SHIFT_RST;
			dm_meta <= 1'h0;
			dm_sync <= 1'h0;
			dm_prev <= 1'h0;
			lc_meta <= 1'h0;
			lc_sync <= 1'h0;
			st_meta <= 1'h0;
			st_sync <= 1'h0;
			st_prev <= 1'h0;
			gt_meta <= 1'h1;
			gt_sync <= 1'h1;
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
			sh_meta <= 8'h00;
			sh_sync <= 8'h00;
			hs_meta <= 8'h00;
			hs_sync <= 8'h00;
			fifo_mem[0] <= '{lsd_pkg::PATTERN_RST, 1'h0};
			fifo_mem[1] <= '{lsd_pkg::PATTERN_RST, 1'h0};
			wr_ptr <= 1'h0;
			rd_ptr <= 1'h0;
			fifo_cnt <= lsd_pkg::FIFO_CNT_RST;
			pattern <= lsd_pkg::PATTERN_RST;
			diag <= lsd_pkg::DIAG_RST;
			sink_channels_out <= lsd_pkg::PATTERN_RST;
			sink_channels_oe_out <= 8'h00;
			low_current_out <= 1'h0;
			load_ready_out <= 1'h1;
		end
		else
		begin
			// shift register is quiet around a load, so per-bit sync is safe
			sr_meta <= shift_reg;
			sr_sync <= sr_meta;
			dm_meta <= (mode != lsd_pkg::LSD_NORMAL);
			dm_sync <= dm_meta;
			dm_prev <= dm_sync;
			lc_meta <= lowcur;
			lc_sync <= lc_meta;
			st_meta <= latch_strobe_in;
			st_sync <= st_meta;
			st_prev <= st_sync;
			gt_meta <= drive_gate_n_in;
			gt_sync <= gt_meta;
			pin_meta <= sink_channels_in;
			pin_sync <= pin_meta;
			sh_meta <= short_sense_in;
			sh_sync <= sh_meta;
			hs_meta <= hot_sense_in;
			hs_sync <= hs_meta;
			fifo_mem <= next_fifo_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fifo_cnt <= next_fifo_cnt;
			pattern <= next_pattern;
			diag <= next_diag;
			sink_channels_out <= next_pattern;
			sink_channels_oe_out <= next_oe;
			low_current_out <= next_low_current;
			load_ready_out <= next_load_ready;
		end
	end

endmodule // lsd_top

// ---- inc/lsd_pkg.sv ----
package lsd_pkg;

	// channel count and serial register width
	localparam int CH_N = 8;
	// serial clock edges with the synced latch strobe high that enter error mode
	localparam int ENTRY_EDGES = 4;
	localparam logic [2:0] ENTRY_CNT_RST = 3'h0;
	localparam logic [7:0] PATTERN_RST = 8'h00;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;
	localparam logic [1:0] FIFO_CNT_RST = 2'h0;
	localparam logic SERIAL_OUT_RST = 1'h1;
	// fastest serial clock the controller may apply
	localparam int SCLK_MAX_MHZ = 50;

	typedef enum logic [4:0]
	{
		LSD_NORMAL = 5'h01,
		LSD_GLOBAL = 5'h02,
		LSD_OPEN = 5'h04,
		LSD_SHORT = 5'h08,
		LSD_TEMP = 5'h10
	} lsd_mode_t;

	typedef struct packed
	{
		logic [7:0] hot;
		logic [7:0] open_led;
		logic [7:0] short_led;
		logic global_fault;
	} lsd_diag_t;

	typedef struct packed
	{
		logic [7:0] pattern;
		logic fault;
	} lsd_word_t;

	localparam lsd_diag_t DIAG_RST = '{8'h00, 8'h00, 8'h00, 1'h0};

endpackage

// ---- testbench/lsd_sva.sv ----
`timescale 1ns/1ps
module lsd_sva
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic serial_clk_in,
	input wire logic serial_bit_in,
	input wire logic latch_strobe_in,
	input wire logic drive_gate_n_in,
	input wire logic [7:0] sink_channels_out,
	input wire logic [7:0] sink_channels_oe_out,
	input wire logic serial_bit_out,
	input wire logic load_ready_out
);
	a_reset_dark: assert property (@(posedge clk_in) disable iff (reset_in)
		$fell(reset_in) |-> sink_channels_out == 8'h00 && sink_channels_oe_out == 8'h00)
		else $error("channels lit after reset");
	a_serout_reset: assert property (@(posedge clk_in) disable iff (reset_in)
		$fell(reset_in) |-> serial_bit_out && load_ready_out)
		else $error("serial out or ready wrong after reset");
	a_oe_subset: assert property (@(posedge clk_in) disable iff (reset_in)
		(sink_channels_oe_out & ~sink_channels_out) == 8'h00)
		else $error("driver on for a dark channel");
	a_gate_off: assert property (@(posedge clk_in) disable iff (reset_in)
		drive_gate_n_in [*4] |=> sink_channels_oe_out == 8'h00)
		else $error("driver on while gated");
	a_gate_on: assert property (@(posedge clk_in) disable iff (reset_in)
		!drive_gate_n_in [*5] |-> sink_channels_oe_out == sink_channels_out)
		else $error("driver off while enabled");
	a_pattern_hold: assert property (@(posedge clk_in) disable iff (reset_in)
		!latch_strobe_in [*8] |=> $stable(sink_channels_out))
		else $error("pattern changed without a load");
	a_ready_idle: assert property (@(posedge clk_in) disable iff (reset_in)
		!latch_strobe_in [*8] |-> load_ready_out)
		else $error("load refused while idle");
	a_serial_delay: assert property (@(posedge serial_clk_in) disable iff (reset_in)
		!latch_strobe_in [*8] ##1 !latch_strobe_in [*8]
		|-> serial_bit_out == $past(serial_bit_in, 9))
		else $error("cascade bit out of step");
endmodule // lsd_sva

// ---- testbench/lsd_ctrl.sv ----
`timescale 1ns/1ps
module lsd_ctrl
#(
	parameter int ENTRY_EDGES = lsd_pkg::ENTRY_EDGES
)
(
	output logic sclk_out,
	output logic sbit_out,
	output logic strobe_out
);
	initial
	begin
		sclk_out = 1'h0;
		sbit_out = 1'h0;
		strobe_out = 1'h0;
	end
	task automatic tick(input logic b);
		sbit_out = b;
		#16 sclk_out = 1'h1;
		#16 sclk_out = 1'h0;
	endtask
	task automatic send(input logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			tick(v[i]);
	endtask
	// clock kept still around the strobe so the copy is clean
	task automatic load();
		strobe_out = 1'h1;
		#320 strobe_out = 1'h0;
		#320;
	endtask
	// strobe-high edges, two lost to sync
	task automatic enter(input logic low);
		strobe_out = 1'h1;
		#320;
		repeat (ENTRY_EDGES + 2)
			tick(low);
		strobe_out = 1'h0;
		#320;
	endtask
endmodule // lsd_ctrl

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
	logic clk_in = 1'h0;
	logic reset_in = 1'h0;
	logic serial_clk_in;
	logic serial_bit_in;
	logic latch_strobe_in;
	logic drive_gate_n_in = 1'h0;
	logic [7:0] open_mask = 8'h00;
	logic [7:0] sink_channels_in;
	logic [7:0] short_sense_in = 8'h00;
	logic [7:0] hot_sense_in = 8'h00;
	logic [7:0] sink_channels_out;
	logic [7:0] sink_channels_oe_out;
	logic serial_bit_out;
	logic low_current_out;
	logic load_ready_out;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	// a driven channel pulls its pin low unless the led is open
	assign sink_channels_in = ~sink_channels_oe_out | open_mask;
	always #20 clk_in = ~clk_in;
	lsd_top u_lsd_top(.clk_in(clk_in), .reset_in(reset_in), .serial_clk_in(serial_clk_in),
		.serial_bit_in(serial_bit_in), .latch_strobe_in(latch_strobe_in),
		.drive_gate_n_in(drive_gate_n_in), .sink_channels_in(sink_channels_in),
		.short_sense_in(short_sense_in), .hot_sense_in(hot_sense_in),
		.sink_channels_out(sink_channels_out), .sink_channels_oe_out(sink_channels_oe_out),
		.serial_bit_out(serial_bit_out), .low_current_out(low_current_out),
		.load_ready_out(load_ready_out));
	lsd_ctrl u_lsd_ctrl(.sclk_out(serial_clk_in), .sbit_out(serial_bit_in),
		.strobe_out(latch_strobe_in));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wclk(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask
	task automatic t_load();
		u_lsd_ctrl.send(8'hA5);
		u_lsd_ctrl.load();
		check("pattern", sink_channels_out, 8'hA5);
		check("oe", sink_channels_oe_out, 8'hA5);
		u_lsd_ctrl.send(8'h3C);
		check("held", sink_channels_out, 8'hA5);
		u_lsd_ctrl.load();
		check("pattern", sink_channels_out, 8'h3C);
	endtask
	task automatic t_gate();
		wclk(1);
		drive_gate_n_in = 1'h1;
		wclk(5);
		check("oe off", sink_channels_oe_out, 8'h00);
		check("held", sink_channels_out, 8'h3C);
		drive_gate_n_in = 1'h0;
		wclk(5);
		check("oe on", sink_channels_oe_out, 8'h3C);
	endtask
	// exp holds the reports of global, open, short and heat modes
	task automatic t_err(input logic lc, input logic [7:0] op, input logic [7:0] sh,
		input logic [7:0] hot, input logic [3:0] exp);
		wclk(1);
		open_mask = op;
		short_sense_in = sh;
		hot_sense_in = hot;
		wclk(4);
		u_lsd_ctrl.enter(lc);
		check("low current", 8'(low_current_out), 8'(lc));
		for (int i = 3; i >= 0; i--)
		begin
			check("report", 8'(serial_bit_out), 8'(exp[i]));
			#400 u_lsd_ctrl.tick(1'h0);
			// report launches on that falling edge
			#2;
		end
		wclk(4);
		check("low current", 8'(low_current_out), 8'h00);
		open_mask = 8'h00;
		short_sense_in = 8'h00;
		hot_sense_in = 8'h00;
	endtask
	task automatic t_cascade(input logic [7:0] a, input logic [7:0] b);
		u_lsd_ctrl.send(a);
		u_lsd_ctrl.send(b);
		#2;
		check("serial out", 8'(serial_bit_out), 8'(a[0]));
		u_lsd_ctrl.load();
		check("pattern", sink_channels_out, b);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		// a real edge, so the link domain resets before its clock ever rises
		#1 reset_in = 1'h1;
		repeat (20) @(posedge clk_in);
		#2 reset_in = 1'h0;
		wclk(1);
		check("pattern", sink_channels_out, 8'h00);
		check("serial out", 8'(serial_bit_out), 8'h01);
		t_load();
		t_gate();
		t_err(1'h0, 8'h04, 8'h08, 8'h00, 4'h1);
		t_err(1'h1, 8'h00, 8'h00, 8'h80, 4'h6);
		t_cascade(8'h01, 8'hFF);
		t_cascade(8'hFE, 8'h00);
		test_done();
	end
	// whole run needs well under a thousand cycles
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			test_done();
		end
	end
endmodule // tb
bind lsd_top lsd_sva u_lsd_sva(.clk_in(clk_in), .reset_in(reset_in),
	.serial_clk_in(serial_clk_in), .serial_bit_in(serial_bit_in),
	.latch_strobe_in(latch_strobe_in), .drive_gate_n_in(drive_gate_n_in),
	.sink_channels_out(sink_channels_out), .sink_channels_oe_out(sink_channels_oe_out),
	.serial_bit_out(serial_bit_out), .load_ready_out(load_ready_out));
